/* hdl/reor_pkg.sv */
// shared constants and types for the rail enable override register bank
package reor_pkg;

  localparam logic [7:0] REOR_OFS_DISABLE   = 8'h9F;
  localparam logic [7:0] REOR_OFS_OVR_A     = 8'hA0;
  localparam logic [7:0] REOR_OFS_OVR_B_GPO = 8'hA1;

  localparam logic [7:0] REOR_RST_DISABLE   = 8'h00;
  localparam logic [7:0] REOR_RST_OVR_A     = 8'h80;
  localparam logic [7:0] REOR_RST_OVR_B_GPO = 8'h89;

  // disable register field positions
  localparam int REOR_DIS_LSW_B2_POS = 7;
  localparam int REOR_DIS_LSW_B1_POS = 6;
  localparam int REOR_DIS_LSW_A1_POS = 5;
  localparam int REOR_DIS_TERM_POS   = 4;

  // override register a field positions, step-down 1..6 in bits 0..5
  localparam int REOR_OVA_LIN_A2_POS = 7;
  localparam int REOR_OVA_LSW_A1_POS = 6;
  localparam int REOR_OVA_SD1_POS    = 0;

  // override b / output level register field positions
  localparam int REOR_OVB_GPO_LSB     = 4;
  localparam int REOR_OVB_TERM_POS    = 3;
  localparam int REOR_OVB_LSW_B2_POS  = 2;
  localparam int REOR_OVB_LSW_B1_POS  = 1;
  localparam int REOR_OVB_LIN_A3_POS  = 0;

  // rail numbering of the enable qualifier vector
  localparam int REOR_RAIL_SD1    = 0;
  localparam int REOR_RAIL_LIN_A2 = 6;
  localparam int REOR_RAIL_LSW_A1 = 7;
  localparam int REOR_RAIL_LIN_A3 = 8;
  localparam int REOR_RAIL_LSW_B1 = 9;
  localparam int REOR_RAIL_LSW_B2 = 10;
  localparam int REOR_RAIL_TERM   = 11;
  localparam int REOR_NUM_RAILS   = 12;
  localparam int REOR_NUM_EXT     = 8;
  localparam int REOR_NUM_SD      = 6;
  localparam int REOR_NUM_GPO     = 4;

  localparam logic [6:0] REOR_DEF_DEV_ADDR = 7'h5E;

  typedef struct packed {
    logic [7:0] disable_sw;
    logic [7:0] ovr_a;
    logic [7:0] ovr_b_gpo;
  } reor_regs_t;

  typedef enum logic [3:0] {
    REOR_ST_IDLE,
    REOR_ST_ADDR,
    REOR_ST_ACK_ADDR,
    REOR_ST_PTR,
    REOR_ST_ACK_PTR,
    REOR_ST_WDATA,
    REOR_ST_ACK_W,
    REOR_ST_RDATA,
    REOR_ST_MACK,
    REOR_ST_RLOAD
  } reor_state_t;

endpackage : reor_pkg

/* hdl/reor_rail_gate.sv */
// one rail's enable qualifier: kill beats force, force beats sequencing
module reor_rail_gate
  import reor_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic permit,
  input  wire logic force_on,
  input  wire logic seq_request,
  output logic      rail_enable
);

  logic enable_reg;
  logic enable_next;

  always_comb
  begin
    // a cleared permit holds the rail off over every other source
    enable_next = permit & (force_on | seq_request);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      enable_reg <= 1'b0;
    end
    else
    begin
      enable_reg <= enable_next;
    end
  end

  assign rail_enable = enable_reg;

endmodule : reor_rail_gate

/* hdl/reor_regs.sv */
// rail enable override registers behind a serial control bus target
module reor_regs
  import reor_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = REOR_DEF_DEV_ADDR
)
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      scl_in,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe_n,
  input  wire logic [REOR_NUM_EXT-1:0]   ext_permit,
  input  wire logic [REOR_NUM_RAILS-1:0] seq_request,
  input  wire logic [REOR_NUM_GPO-1:0]   gpo_is_output,
  output logic      [REOR_NUM_RAILS-1:0] rail_enable,
  output logic      [REOR_NUM_GPO-1:0]   gpo_level,
  output logic      [REOR_NUM_GPO-1:0]   gpo_oe_n
);

  // reserved and general call addresses cannot be served
  if (DEV_ADDR < 7'h08 || DEV_ADDR > 7'h77)
  begin : g_bad_addr
    $error("device address lies in a reserved range");
  end

  // pin synchronisers; stage one feeds stage two only
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic [2:0] scl_sync_next;
  logic [2:0] sda_sync_next;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       sda_s;

  always_comb
  begin
    scl_sync_next = {scl_sync_reg[1:0], scl_in};
    sda_sync_next = {sda_sync_reg[1:0], sda_in};
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
    end
    else
    begin
      scl_sync_reg <= scl_sync_next;
      sda_sync_reg <= sda_sync_next;
    end
  end

  assign sda_s     = sda_sync_reg[1];
  assign scl_rise  = scl_sync_reg[1] & ~scl_sync_reg[2];
  assign scl_fall  = ~scl_sync_reg[1] & scl_sync_reg[2];
  assign start_det = scl_sync_reg[1] & scl_sync_reg[2] & ~sda_sync_reg[1] & sda_sync_reg[2];
  assign stop_det  = scl_sync_reg[1] & scl_sync_reg[2] & sda_sync_reg[1] & ~sda_sync_reg[2];

  // target engine and register file
  reor_state_t state_reg;
  reor_state_t state_next;
  logic [3:0]  cnt_reg;
  logic [3:0]  cnt_next;
  logic [7:0]  shift_reg;
  logic [7:0]  shift_next;
  logic [7:0]  ptr_reg;
  logic [7:0]  ptr_next;
  logic        rw_reg;
  logic        rw_next;
  logic        drive_low_reg;
  logic        drive_low_next;
  reor_regs_t  regs_reg;
  reor_regs_t  regs_next;
  logic [7:0]  rd_byte;

  always_comb
  begin
    // reads are pure decode, a read leaves the register file unchanged
    case (ptr_reg)
      REOR_OFS_DISABLE:   rd_byte = regs_reg.disable_sw;
      REOR_OFS_OVR_A:     rd_byte = regs_reg.ovr_a;
      REOR_OFS_OVR_B_GPO: rd_byte = regs_reg.ovr_b_gpo;
      default:            rd_byte = 8'h00;
    endcase
  end

  always_comb
  begin
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    shift_next     = shift_reg;
    ptr_next       = ptr_reg;
    rw_next        = rw_reg;
    drive_low_next = drive_low_reg;
    regs_next      = regs_reg;
    if (start_det)
    begin
      state_next     = REOR_ST_ADDR;
      cnt_next       = 4'h0;
      drive_low_next = 1'b0;
    end
    else if (stop_det)
    begin
      state_next     = REOR_ST_IDLE;
      drive_low_next = 1'b0;
    end
    else
    begin
      case (state_reg)
        REOR_ST_IDLE:
        begin
          drive_low_next = 1'b0;
        end
        REOR_ST_ADDR, REOR_ST_PTR, REOR_ST_WDATA:
        begin
          if (scl_rise)
          begin
            shift_next = {shift_reg[6:0], sda_s};
            cnt_next   = cnt_reg + 4'h1;
          end
          else if (scl_fall && cnt_reg == 4'h8)
          begin
            drive_low_next = 1'b1;
            if (state_reg == REOR_ST_ADDR)
            begin
              if (shift_reg[7:1] == DEV_ADDR)
              begin
                rw_next    = shift_reg[0];
                state_next = REOR_ST_ACK_ADDR;
              end
              else
              begin
                drive_low_next = 1'b0;
                state_next     = REOR_ST_IDLE;
              end
            end
            else if (state_reg == REOR_ST_PTR)
            begin
              ptr_next   = shift_reg;
              state_next = REOR_ST_ACK_PTR;
            end
            else
            begin
              // reserved disable bits are stored as written
              case (ptr_reg)
                REOR_OFS_DISABLE:   regs_next.disable_sw = shift_reg;
                REOR_OFS_OVR_A:     regs_next.ovr_a = shift_reg;
                REOR_OFS_OVR_B_GPO: regs_next.ovr_b_gpo = shift_reg;
                default:            regs_next = regs_reg;
              endcase
              ptr_next   = ptr_reg + 8'h01;
              state_next = REOR_ST_ACK_W;
            end
          end
        end
        REOR_ST_ACK_ADDR:
        begin
          if (scl_fall)
          begin
            cnt_next = 4'h0;
            if (rw_reg)
            begin
              shift_next     = rd_byte;
              drive_low_next = ~rd_byte[7];
              state_next     = REOR_ST_RDATA;
            end
            else
            begin
              drive_low_next = 1'b0;
              state_next     = REOR_ST_PTR;
            end
          end
        end
        REOR_ST_ACK_PTR, REOR_ST_ACK_W:
        begin
          if (scl_fall)
          begin
            cnt_next       = 4'h0;
            drive_low_next = 1'b0;
            state_next     = REOR_ST_WDATA;
          end
        end
        REOR_ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (cnt_reg == 4'h7)
            begin
              drive_low_next = 1'b0;
              state_next     = REOR_ST_MACK;
            end
            else
            begin
              cnt_next       = cnt_reg + 4'h1;
              shift_next     = {shift_reg[6:0], 1'b0};
              drive_low_next = ~shift_reg[6];
            end
          end
        end
        REOR_ST_MACK:
        begin
          if (scl_rise)
          begin
            // a not-acknowledge ends the read; wait for stop or restart
            if (!sda_s)
            begin
              ptr_next   = ptr_reg + 8'h01;
              state_next = REOR_ST_RLOAD;
            end
            else
            begin
              state_next = REOR_ST_IDLE;
            end
          end
        end
        REOR_ST_RLOAD:
        begin
          if (scl_fall)
          begin
            cnt_next       = 4'h0;
            shift_next     = rd_byte;
            drive_low_next = ~rd_byte[7];
            state_next     = REOR_ST_RDATA;
          end
        end
        default:
        begin
          state_next     = REOR_ST_IDLE;
          drive_low_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg           <= REOR_ST_IDLE;
      cnt_reg             <= 4'h0;
      shift_reg           <= 8'h00;
      ptr_reg             <= 8'h00;
      rw_reg              <= 1'b0;
      drive_low_reg       <= 1'b0;
      regs_reg.disable_sw <= REOR_RST_DISABLE;
      regs_reg.ovr_a      <= REOR_RST_OVR_A;
      regs_reg.ovr_b_gpo  <= REOR_RST_OVR_B_GPO;
    end
    else
    begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      shift_reg     <= shift_next;
      ptr_reg       <= ptr_next;
      rw_reg        <= rw_next;
      drive_low_reg <= drive_low_next;
      regs_reg      <= regs_next;
    end
  end

  // open drain: only ever pulls low
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~drive_low_reg;

  // per-rail permit and force vectors
  logic [REOR_NUM_RAILS-1:0] permit;
  logic [REOR_NUM_RAILS-1:0] force_on;

  always_comb
  begin
    permit   = '0;
    force_on = '0;
    // rails killed elsewhere arrive through ext_permit
    permit[REOR_NUM_SD-1:0]  = ext_permit[REOR_NUM_SD-1:0];
    permit[REOR_RAIL_LIN_A2] = ext_permit[REOR_NUM_SD];
    permit[REOR_RAIL_LIN_A3] = ext_permit[REOR_NUM_SD+1];
    permit[REOR_RAIL_LSW_B2] = regs_reg.disable_sw[REOR_DIS_LSW_B2_POS];
    permit[REOR_RAIL_LSW_B1] = regs_reg.disable_sw[REOR_DIS_LSW_B1_POS];
    permit[REOR_RAIL_LSW_A1] = regs_reg.disable_sw[REOR_DIS_LSW_A1_POS];
    permit[REOR_RAIL_TERM]   = regs_reg.disable_sw[REOR_DIS_TERM_POS];
    force_on[REOR_RAIL_SD1 +: REOR_NUM_SD] =
      regs_reg.ovr_a[REOR_OVA_SD1_POS +: REOR_NUM_SD];
    force_on[REOR_RAIL_LIN_A2] = regs_reg.ovr_a[REOR_OVA_LIN_A2_POS];
    force_on[REOR_RAIL_LSW_A1] = regs_reg.ovr_a[REOR_OVA_LSW_A1_POS];
    force_on[REOR_RAIL_TERM]   = regs_reg.ovr_b_gpo[REOR_OVB_TERM_POS];
    force_on[REOR_RAIL_LSW_B2] = regs_reg.ovr_b_gpo[REOR_OVB_LSW_B2_POS];
    force_on[REOR_RAIL_LSW_B1] = regs_reg.ovr_b_gpo[REOR_OVB_LSW_B1_POS];
    force_on[REOR_RAIL_LIN_A3] = regs_reg.ovr_b_gpo[REOR_OVB_LIN_A3_POS];
  end

  for (genvar i = 0; i < REOR_NUM_RAILS; i++)
  begin : g_rail
    // clear override leaves seq_request in charge, set forces on while permit is set
    reor_rail_gate u_gate (
      .clk         (clk),
      .rst         (rst),
      .permit      (permit[i]),
      .force_on    (force_on[i]),
      .seq_request (seq_request[i]),
      .rail_enable (rail_enable[i])
    );
  end

  // general outputs
  logic [REOR_NUM_GPO-1:0] gpo_level_reg;
  logic [REOR_NUM_GPO-1:0] gpo_level_next;
  logic [REOR_NUM_GPO-1:0] gpo_oe_n_reg;
  logic [REOR_NUM_GPO-1:0] gpo_oe_n_next;

  always_comb
  begin
    gpo_level_next = regs_reg.ovr_b_gpo[REOR_OVB_GPO_LSB +: REOR_NUM_GPO];
    gpo_oe_n_next  = ~gpo_is_output;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      gpo_level_reg <= '0;
      gpo_oe_n_reg  <= '1;
    end
    else
    begin
      gpo_level_reg <= gpo_level_next;
      gpo_oe_n_reg  <= gpo_oe_n_next;
    end
  end

  assign gpo_level = gpo_level_reg;
  assign gpo_oe_n  = gpo_oe_n_reg;

endmodule : reor_regs

/* verif/reor_regs_asserts.sv */
// concurrent checks on the ports of the rail enable override register bank
module reor_regs_asserts
  import reor_pkg::*;
(
  input wire logic                      clk,
  input wire logic                      rst,
  input wire logic                      scl_in,
  input wire logic                      sda_in,
  input wire logic                      sda_out,
  input wire logic                      sda_oe_n,
  input wire logic [REOR_NUM_EXT-1:0]   ext_permit,
  input wire logic [REOR_NUM_RAILS-1:0] seq_request,
  input wire logic [REOR_NUM_GPO-1:0]   gpo_is_output,
  input wire logic [REOR_NUM_RAILS-1:0] rail_enable,
  input wire logic [REOR_NUM_GPO-1:0]   gpo_level,
  input wire logic [REOR_NUM_GPO-1:0]   gpo_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  a_ext_permit_gate : assert property (
    !$past(rst) |-> ({rail_enable[8], rail_enable[6:0]} & ~$past(ext_permit)) == 8'h00)
    else $error("rail enabled without permit");
  a_seq_follow : assert property (
    !$past(rst) |-> (~{rail_enable[8], rail_enable[6:0]}
      & $past(ext_permit & {seq_request[8], seq_request[6:0]})) == 8'h00)
    else $error("permitted rail ignored its request");
  a_reset_quiet : assert property (
    $past(rst) |-> rail_enable == 12'h000 && gpo_level == 4'h0 && gpo_oe_n == 4'hF && sda_oe_n)
    else $error("outputs not quiet out of reset");
  a_level_after_rst : assert property (
    $past(rst) |=> gpo_level == 4'h8)
    else $error("output levels wrong after reset");
  a_kill_at_start : assert property (
    $past(rst) |=> rail_enable[11:9] == 3'b000 && !rail_enable[7])
    else $error("gated rail on before its disable bit is set");
  a_gpo_oe_track : assert property (
    !$past(rst) |-> gpo_oe_n == ~$past(gpo_is_output))
    else $error("output enable does not follow config");
  a_ack_stands : assert property (
    scl_in [*4] |-> $stable(sda_oe_n))
    else $error("data line moved while clock high");
  a_level_stands : assert property (
    scl_in [*6] |-> $stable(gpo_level))
    else $error("output level moved while clock high");
endmodule : reor_regs_asserts

bind reor_regs reor_regs_asserts u_chk (
  .clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .ext_permit(ext_permit), .seq_request(seq_request),
  .gpo_is_output(gpo_is_output), .rail_enable(rail_enable), .gpo_level(gpo_level),
  .gpo_oe_n(gpo_oe_n));

/* verif/reor_host_model.sv */
// serial bus host driving the register bank, open drain data with pull-up wire, clock driven push-pull
module reor_host_model
  import reor_pkg::*;
#(
  parameter int HALF = 8
)
(
  input  wire logic clk,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial scl = 1'b1;
  initial sda_oe_n = 1'b1;

  // half phase of 8 clocks leaves margin over the 2-flop input sync
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic put_bit(input logic b);
    tick(HALF / 2);
    sda_oe_n = b;
    tick(HALF / 2);
    scl = 1'b1;
    tick(HALF);
    scl = 1'b0;
  endtask : put_bit
  task automatic get_bit(output logic b);
    tick(HALF / 2);
    sda_oe_n = 1'b1;
    tick(HALF / 2);
    scl = 1'b1;
    tick(HALF / 2);
    b = sda_wire;
    tick(HALF / 2);
    scl = 1'b0;
  endtask : get_bit
  // also serves as repeated start when entered with the clock low
  task automatic start_cond;
    tick(HALF / 2);
    sda_oe_n = 1'b1;
    tick(HALF / 2);
    scl = 1'b1;
    tick(HALF);
    sda_oe_n = 1'b0;
    tick(HALF);
    scl = 1'b0;
  endtask : start_cond
  task automatic stop_cond;
    tick(HALF / 2);
    sda_oe_n = 1'b0;
    tick(HALF / 2);
    scl = 1'b1;
    tick(HALF);
    sda_oe_n = 1'b1;
    tick(HALF);
  endtask : stop_cond
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i]);
    get_bit(a);
    ack = ~a;
  endtask : send_byte
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d,
                           output logic [2:0] acks);
    start_cond();
    send_byte({dev, 1'b0}, acks[2]);
    send_byte(p, acks[1]);
    send_byte(d, acks[0]);
    stop_cond();
  endtask : write_reg
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] p, output logic [7:0] d,
                          output logic [2:0] acks);
    start_cond();
    send_byte({dev, 1'b0}, acks[2]);
    send_byte(p, acks[1]);
    start_cond();
    send_byte({dev, 1'b1}, acks[0]);
    for (int i = 7; i >= 0; i--)
      get_bit(d[i]);
    put_bit(1'b1);
    stop_cond();
  endtask : read_reg
endmodule : reor_host_model

/* verif/tb_top.sv */
// self-checking bench for the rail enable override register bank
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top
  import reor_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] DEV = 7'h2A;  // arbitrary target address
  localparam logic [23:0] CFG [5] = '{24'h008089, 24'h007F89, 24'hF0405E, 24'hF000A0,
                                      24'hA0C536};
  localparam logic [19:0] IO [5] = '{20'hFF000, 20'hFFFFF, 20'h7F000, 20'hFFA5A, 20'h55300};
  logic        clk = 1'b0;
  logic        rst;
  logic        scl;
  logic        host_oe_n;
  logic        sda_out;
  logic        sda_oe_n;
  logic        sda_wire;
  logic [7:0]  ext_permit;
  logic [11:0] seq_request;
  logic [3:0]  gpo_is_output;
  logic [11:0] rail_enable;
  logic [3:0]  gpo_level;
  logic [3:0]  gpo_oe_n;
  logic [2:0]  acks;
  logic [7:0]  rdat;
  reor_regs_t  r;
  int          n_mismatch = 0;
  int          samples_checked = 0;

  always #5 clk = ~clk;
  assign sda_wire = (sda_oe_n ? 1'b1 : sda_out) & host_oe_n;

  reor_regs #(.DEV_ADDR(DEV)) dut (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .ext_permit(ext_permit), .seq_request(seq_request),
    .gpo_is_output(gpo_is_output), .rail_enable(rail_enable), .gpo_level(gpo_level),
    .gpo_oe_n(gpo_oe_n));
  reor_host_model host (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_oe_n(host_oe_n));

  function automatic logic [11:0] exp_rails(input reor_regs_t c, input logic [7:0] p,
                                            input logic [11:0] s);
    logic [11:0] perm;
    logic [11:0] frc;
    perm = {c.disable_sw[4], c.disable_sw[7], c.disable_sw[6], p[7], c.disable_sw[5], p[6:0]};
    frc = {c.ovr_b_gpo[3:0], c.ovr_a[6], c.ovr_a[7], c.ovr_a[5:0]};
    return perm & (frc | s);
  endfunction : exp_rails
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    host.write_reg(DEV, p, d, acks);
    `CHK(acks, 3'b111)
  endtask : wr
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    host.read_reg(DEV, p, rdat, acks);
    `CHK(acks, 3'b111)
    `CHK(rdat, e)
  endtask : rd
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // a full run needs about 23k clocks; give it 40k before calling it hung
  initial
  begin
    #400000;
    n_mismatch++;
    wrap_up();
  end

  initial
  begin
    rst = 1'b1;
    ext_permit = 8'h00;
    seq_request = 12'h000;
    gpo_is_output = 4'hF;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK(gpo_level, 4'h8)
    `CHK(rail_enable, 12'h000)
    rd(8'h9F, 8'h00);
    rd(8'hA0, 8'h80);
    rd(8'hA1, 8'h89);
    rd(8'h9E, 8'h00);
    host.write_reg(DEV ^ 7'h01, 8'hA0, 8'h00, acks);
    `CHK(acks, 3'b000)
    rd(8'hA0, 8'h80);
    for (int i = 0; i < 5; i++)
    begin
      r = reor_regs_t'(CFG[i]);
      wr(8'h9F, r.disable_sw);
      wr(8'hA0, r.ovr_a);
      wr(8'hA1, r.ovr_b_gpo);
      @(posedge clk);
      #1;
      ext_permit = IO[i][19:12];
      seq_request = IO[i][11:0];
      gpo_is_output = 4'(i + 6);
      repeat (2) @(posedge clk);
      #1;
      `CHK(rail_enable, exp_rails(r, IO[i][19:12], IO[i][11:0]))
      `CHK(gpo_level, r.ovr_b_gpo[7:4])
      `CHK(gpo_oe_n, ~gpo_is_output)
      rd(8'h9F, r.disable_sw);
      rd(8'hA0, r.ovr_a);
      rd(8'hA1, r.ovr_b_gpo);
    end
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK(rail_enable, 12'h000)
    rst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    rd(8'h9F, 8'h00);
    rd(8'hA1, 8'h89);
    rd(8'hA1, 8'h89);
    wrap_up();
  end
endmodule : tb_top
